// File: clk_seq_pkg.sv
// Purpose: shared constants for the clock bring-up controller
// Assumes: device registers sit on a byte-addressed APB at 32-bit words
// Notes:   device map, own register map and field layouts live here
package clk_seq_pkg;
    // ----------------------------------------
    // device side register map
    // ----------------------------------------
    localparam int         DEV_AW      = 8;
    localparam logic [7:0] D_SUB_CTRL  = 8'h00;
    localparam logic [7:0] D_SUB_DRV   = 8'h04;
    localparam logic [7:0] D_SUB_WAIT  = 8'h08; // sub_osc_wait_time_reg
    localparam logic [7:0] D_MAIN_DRV  = 8'h0C;
    localparam logic [7:0] D_MAIN_WAIT = 8'h10; // main_osc_wait_time_reg
    localparam logic [7:0] D_MAIN_CTRL = 8'h14;
    localparam logic [7:0] D_FAST_CTRL = 8'h18;
    localparam logic [7:0] D_FAST_FREQ = 8'h1C;
    localparam logic [7:0] D_PLL_CTRL  = 8'h20;
    localparam logic [7:0] D_PLL_CFG   = 8'h24;
    localparam logic [7:0] D_FLAGS     = 8'h28; // osc_stable_flags_reg
    localparam logic [7:0] D_PWR_MODE  = 8'h2C;
    localparam logic [7:0] D_DIV       = 8'h30;
    localparam logic [7:0] D_SYS_SEL   = 8'h34;
    localparam int          FLAG_MAIN  = 0;
    localparam int          FLAG_SUB   = 1;
    localparam int          FLAG_PLL   = 2;
    localparam int          FLAG_FAST  = 3;
    localparam logic [31:0] OSC_RUN    = 32'h0000_0000;
    localparam logic [31:0] OSC_STOP   = 32'h0000_0001;
    localparam logic [1:0]  FREQ_16    = 2'h0;
    localparam logic [1:0]  FREQ_18    = 2'h1;
    localparam logic [1:0]  FREQ_20    = 2'h2;
    localparam logic [1:0]  SRC_PLL    = 2'h0;
    localparam logic [1:0]  SRC_FAST   = 2'h1;
    localparam logic [1:0]  SRC_MAIN   = 2'h2;
    localparam logic [1:0]  SRC_SUB    = 2'h3;
    localparam logic [1:0]  PWR_HIGH   = 2'h0;
    // ----------------------------------------
    // own register map and reset values
    // ----------------------------------------
    localparam logic [7:0]  R_CTRL     = 8'h00;
    localparam logic [7:0]  R_CFG      = 8'h04;
    localparam logic [7:0]  R_MAIN     = 8'h08;
    localparam logic [7:0]  R_SUB      = 8'h0C;
    localparam logic [7:0]  R_PLL      = 8'h10;
    localparam logic [7:0]  R_DIV      = 8'h14;
    localparam logic [7:0]  R_STATUS   = 8'h18;
    localparam int          CFG_SUB    = 0;
    localparam int          CFG_MAIN   = 1;
    localparam int          CFG_FAST   = 2;
    localparam int          CFG_PLL    = 3;
    localparam int          CFG_FREQ   = 4;
    localparam int          CFG_SRC    = 6;
    localparam int          CFG_PWR    = 8;
    localparam logic [31:0] CFG_DEF    = 32'h0000_002A;
    localparam logic [31:0] MAIN_DEF   = 32'h0000_5300;
    localparam logic [31:0] SUB_DEF    = 32'h0000_2100;
    localparam logic [31:0] PLL_DEF    = 32'h0000_1300;
    localparam logic [31:0] DIV_DEF    = 32'h1222_2211;
    localparam logic [4:0]  STEP_LAST  = 5'd19;
    typedef enum logic [1:0] {OP_SKIP = 2'h0, OP_WR = 2'h1, OP_POLL = 2'h2} op_kind_e;
    typedef struct packed {
        op_kind_e    kind;
        logic [7:0]  addr;
        logic [31:0] data;
    } op_s;
endpackage

// File: apb_req_master.sv
// Purpose: single-request APB master toward the device
// Assumes: req_in is a one-cycle pulse given only while idle
// Notes:   ack_out rises on the completing edge and stays high for one cycle
`timescale 1ns/10ps
module apb_req_master #(
    parameter int AW = clk_seq_pkg::DEV_AW
) (
    input  wire logic          mclk_in,     // clock
    input  wire logic          rst_in,      // sync reset
    input  wire logic          req_in,      // start request
    input  wire logic          wr_in,       // 1 write
    input  wire logic [AW-1:0] addr_in,     // address
    input  wire logic [31:0]   wdata_in,    // write data
    input  wire logic [31:0]   prdata_in,   // apb read data
    input  wire logic          pready_in,   // apb ready
    output logic               psel_out,    // apb select
    output logic               penable_out, // apb enable
    output logic               pwrite_out,  // apb direction
    output logic [AW-1:0]      paddr_out,   // apb address
    output logic [31:0]        pwdata_out,  // apb write data
    output logic               ack_out,     // done pulse
    output logic [31:0]        rdata_out    // captured read
);
    import clk_seq_pkg::*;
    if (AW < 8) begin : g_aw_chk
        $error("address width too small");
    end
    typedef struct packed {
        logic          sel;
        logic          en;
        logic          wr;
        logic [AW-1:0] addr;
        logic [31:0]   wdata;
        logic          ack;
        logic [31:0]   rdata;
    } mst_s;
    mst_s r_reg, r_next;
    always_comb begin
        r_next = r_reg;
        r_next.ack = 1'b0;
        if (!r_reg.sel) begin
            if (req_in) begin
                r_next.sel = 1'b1;
                r_next.wr = wr_in;
                r_next.addr = addr_in;
                r_next.wdata = wdata_in;
            end
        end else if (!r_reg.en) begin
            r_next.en = 1'b1;
        end else if (pready_in) begin
            r_next.sel = 1'b0;
            r_next.en = 1'b0;
            r_next.ack = 1'b1;
            if (!r_reg.wr) begin
                r_next.rdata = prdata_in;
            end
        end
    end
    always_ff @(posedge mclk_in) begin
        if (rst_in) r_reg <= '0;
        else r_reg <= r_next;
    end
    assign psel_out = r_reg.sel;
    assign penable_out = r_reg.en;
    assign pwrite_out = r_reg.wr;
    assign paddr_out = r_reg.addr;
    assign pwdata_out = r_reg.wdata;
    assign ack_out = r_reg.ack;
    assign rdata_out = r_reg.rdata;
endmodule // apb_req_master

// File: apb_slave_port.sv
// Purpose: APB slave handshake for the controller's own registers
// Assumes: rdata_in and err_in decode paddr combinationally
// Notes:   one wait state; writes land on the edge that sees pready
`timescale 1ns/10ps
module apb_slave_port (
    input  wire logic        mclk_in,     // clock
    input  wire logic        rst_in,      // sync reset
    input  wire logic        psel_in,     // apb select
    input  wire logic        penable_in,  // apb enable
    input  wire logic        pwrite_in,   // apb direction
    input  wire logic [31:0] rdata_in,    // decoded read data
    input  wire logic        err_in,      // unmapped address
    output logic             pready_out,  // apb ready
    output logic [31:0]      prdata_out,  // apb read data
    output logic             pslverr_out, // apb error
    output logic             wr_out       // write strobe
);
    import clk_seq_pkg::*;
    typedef struct packed {
        logic        rdy;
        logic [31:0] rdata;
        logic        err;
    } slv_s;
    slv_s r_reg, r_next;
    always_comb begin
        r_next = r_reg;
        r_next.rdy = 1'b0;
        r_next.err = 1'b0;
        if (psel_in && penable_in && !r_reg.rdy) begin
            r_next.rdy = 1'b1;
            r_next.err = err_in;
            r_next.rdata = pwrite_in ? 32'h0000_0000 : rdata_in;
        end
    end
    always_ff @(posedge mclk_in) begin
        if (rst_in) r_reg <= '0;
        else r_reg <= r_next;
    end
    assign pready_out = r_reg.rdy;
    assign prdata_out = r_reg.rdata;
    assign pslverr_out = r_reg.err;
    assign wr_out = psel_in && penable_in && pwrite_in && r_reg.rdy && !r_reg.err;
endmodule // apb_slave_port

// File: clock_bringup_sequencer.sv
// Purpose: drives the device's oscillators, PLL and dividers after reset
// Assumes: device registers answer on an APB master port
// Notes:   runs once from reset; software may rerun it via the go bit
//
// Notes on behaviour
// - seven ordered steps: sub, main, fast, pll, power mode, dividers, source switch
// - sub oscillator always initialized; if used, drive, wait, start, await stable
// - main oscillator used: drive, wait time, start, await stable; unused: nothing
// - unused fast on-chip oscillator gets its power switched off
// - used fast oscillator: select frequency, start, await stable flag
// - unused PLL gets its power switched off in the PLL step
// - used PLL: program division and multiplication, start, await stable flag
// - stabilization waits end only on the device's flag bit reading 1
// - power mode set after sources; default high-speed mode
// - default dividers: core, periph A half; others quarter; bus clock out stopped
// - last step switches system clock source; default is PLL
// - default: main oscillator and PLL on, fast and sub oscillators off
// - fast oscillator frequency 16, 18 or 20 MHz, default 20 MHz
// - system clock source: PLL, fast oscillator, main or sub oscillator
`timescale 1ns/10ps
module clock_bringup_sequencer (
    input  wire logic        mclk_in,         // 200 MHz clock
    input  wire logic        rst_in,          // sync reset
    input  wire logic        psel_in,         // apb select
    input  wire logic        penable_in,      // apb enable
    input  wire logic        pwrite_in,       // apb direction
    input  wire logic [7:0]  paddr_in,        // apb address
    input  wire logic [31:0] pwdata_in,       // apb write data
    output logic             pready_out,      // apb ready
    output logic [31:0]      prdata_out,      // apb read data
    output logic             pslverr_out,     // apb error
    output logic             dev_psel_out,    // device select
    output logic             dev_penable_out, // device enable
    output logic             dev_pwrite_out,  // device direction
    output logic [7:0]       dev_paddr_out,   // device address
    output logic [31:0]      dev_pwdata_out,  // device write data
    input  wire logic [31:0] dev_prdata_in,   // device read data
    input  wire logic        dev_pready_in,   // device ready
    output logic             busy_out,        // sequence running
    output logic             done_out         // sequence finished
);
    import clk_seq_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [3:0] {
        S_IDLE  = 4'b0001,
        S_FETCH = 4'b0010,
        S_WAIT  = 4'b0100,
        S_DONE  = 4'b1000
    } seq_e;

    typedef struct packed {
        seq_e        st;
        logic [4:0]  step;
        logic        go;
        logic        busy;
        logic        done;
        logic        req;
        logic [31:0] cfg;
        logic [31:0] main;
        logic [31:0] sub;
        logic [31:0] pll;
        logic [31:0] div;
    } seq_s;

    // auto-start after reset with the default set
    localparam seq_s SEQ_RST = '{
        st:   S_IDLE,
        step: 5'd0,
        go:   1'b1,
        busy: 1'b0,
        done: 1'b0,
        req:  1'b0,
        cfg:  CFG_DEF,
        main: MAIN_DEF,
        sub:  SUB_DEF,
        pll:  PLL_DEF,
        div:  DIV_DEF
    };

    seq_s        r_reg;
    seq_s        r_next;
    op_s         op;
    logic        ack;
    logic [31:0] rdata;
    logic [31:0] reg_rdata;
    logic        reg_err;
    logic        wr_en;

    // ----------------------------------------
    // step table
    // ----------------------------------------
    function automatic op_kind_e gate(input logic en, input op_kind_e k);
        return en ? k : OP_SKIP;
    endfunction

    function automatic op_s op_of(input logic [4:0] s, input logic [31:0] c,
                                  input logic [31:0] m, input logic [31:0] u,
                                  input logic [31:0] p, input logic [31:0] d);
        op_s o;
        o.kind = OP_WR;
        o.addr = D_SUB_CTRL;
        o.data = OSC_STOP;
        unique case (s)
            5'd0: begin
                o.kind = OP_WR;
            end
            5'd1: begin
                o.kind = gate(c[CFG_SUB], OP_WR);
                o.addr = D_SUB_DRV;
                o.data = {24'h00_0000, u[7:0]};
            end
            5'd2: begin
                o.kind = gate(c[CFG_SUB], OP_WR);
                o.addr = D_SUB_WAIT;
                o.data = {24'h00_0000, u[15:8]};
            end
            5'd3: begin
                o.kind = gate(c[CFG_SUB], OP_WR);
                o.data = OSC_RUN;
            end
            5'd4: begin
                o.kind = gate(c[CFG_SUB], OP_POLL);
                o.addr = D_FLAGS;
                o.data = 32'h0000_0001 << FLAG_SUB;
            end
            5'd5: begin
                o.kind = gate(c[CFG_MAIN], OP_WR);
                o.addr = D_MAIN_DRV;
                o.data = {24'h00_0000, m[7:0]};
            end
            5'd6: begin
                o.kind = gate(c[CFG_MAIN], OP_WR);
                o.addr = D_MAIN_WAIT;
                o.data = {24'h00_0000, m[15:8]};
            end
            5'd7: begin
                o.kind = gate(c[CFG_MAIN], OP_WR);
                o.addr = D_MAIN_CTRL;
                o.data = OSC_RUN;
            end
            5'd8: begin
                o.kind = gate(c[CFG_MAIN], OP_POLL);
                o.addr = D_FLAGS;
                o.data = 32'h0000_0001 << FLAG_MAIN;
            end
            5'd9: begin
                o.kind = gate(!c[CFG_FAST], OP_WR);
                o.addr = D_FAST_CTRL;
                o.data = OSC_STOP;
            end
            5'd10: begin
                o.kind = gate(c[CFG_FAST], OP_WR);
                o.addr = D_FAST_FREQ;
                o.data = {30'h0, c[CFG_FREQ +: 2]};
            end
            5'd11: begin
                o.kind = gate(c[CFG_FAST], OP_WR);
                o.addr = D_FAST_CTRL;
                o.data = OSC_RUN;
            end
            5'd12: begin
                o.kind = gate(c[CFG_FAST], OP_POLL);
                o.addr = D_FLAGS;
                o.data = 32'h0000_0001 << FLAG_FAST;
            end
            5'd13: begin
                o.kind = gate(!c[CFG_PLL], OP_WR);
                o.addr = D_PLL_CTRL;
                o.data = OSC_STOP;
            end
            5'd14: begin
                o.kind = gate(c[CFG_PLL], OP_WR);
                o.addr = D_PLL_CFG;
                o.data = {16'h0000, p[15:0]};
            end
            5'd15: begin
                o.kind = gate(c[CFG_PLL], OP_WR);
                o.addr = D_PLL_CTRL;
                o.data = OSC_RUN;
            end
            5'd16: begin
                o.kind = gate(c[CFG_PLL], OP_POLL);
                o.addr = D_FLAGS;
                o.data = 32'h0000_0001 << FLAG_PLL;
            end
            5'd17: begin
                o.addr = D_PWR_MODE;
                o.data = {30'h0, c[CFG_PWR +: 2]};
            end
            5'd18: begin
                o.addr = D_DIV;
                o.data = d;
            end
            5'd19: begin
                o.addr = D_SYS_SEL;
                o.data = {30'h0, c[CFG_SRC +: 2]};
            end
            default: begin
                o.kind = OP_SKIP;
            end
        endcase
        return o;
    endfunction

    assign op = op_of(r_reg.step, r_reg.cfg, r_reg.main, r_reg.sub, r_reg.pll, r_reg.div);

    // ----------------------------------------
    // own register decode
    // ----------------------------------------
    always_comb begin
        reg_err = 1'b0;
        unique case (paddr_in)
            R_CTRL:   reg_rdata = 32'h0000_0000;
            R_CFG:    reg_rdata = r_reg.cfg;
            R_MAIN:   reg_rdata = r_reg.main;
            R_SUB:    reg_rdata = r_reg.sub;
            R_PLL:    reg_rdata = r_reg.pll;
            R_DIV:    reg_rdata = r_reg.div;
            R_STATUS: reg_rdata = {19'h0, r_reg.step, 6'h0, r_reg.done, r_reg.busy};
            default: begin
                reg_rdata = 32'h0000_0000;
                reg_err = 1'b1;
            end
        endcase
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb begin
        r_next = r_reg;
        r_next.req = 1'b0;
        // config is frozen while running so the table cannot shift under a step
        if (wr_en && !r_reg.busy) begin
            unique case (paddr_in)
                R_CFG:   r_next.cfg = pwdata_in;
                R_MAIN:  r_next.main = pwdata_in;
                R_SUB:   r_next.sub = pwdata_in;
                R_PLL:   r_next.pll = pwdata_in;
                R_DIV:   r_next.div = pwdata_in;
                default: r_next.cfg = r_reg.cfg;
            endcase
        end
        unique case (r_reg.st)
            S_IDLE: begin
                if (r_reg.go) begin
                    r_next.go = 1'b0;
                    r_next.step = 5'd0;
                    r_next.done = 1'b0;
                    r_next.busy = 1'b1;
                    r_next.st = S_FETCH;
                end
            end
            S_FETCH: begin
                if (r_reg.step > STEP_LAST) begin
                    r_next.st = S_DONE;
                end else if (op.kind == OP_SKIP) begin
                    r_next.step = r_reg.step + 5'd1;
                end else begin
                    r_next.req = 1'b1;
                    r_next.st = S_WAIT;
                end
            end
            S_WAIT: begin
                if (ack) begin
                    if (op.kind == OP_POLL && (rdata & op.data) == 32'h0000_0000) begin
                        r_next.req = 1'b1;
                    end else begin
                        r_next.step = r_reg.step + 5'd1;
                        r_next.st = S_FETCH;
                    end
                end
            end
            S_DONE: begin
                r_next.done = 1'b1;
                r_next.busy = 1'b0;
                r_next.st = S_IDLE;
            end
        endcase
        // a go write beats the take in the same cycle
        if (wr_en && paddr_in == R_CTRL && pwdata_in[0]) begin
            r_next.go = 1'b1;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            r_reg <= SEQ_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign busy_out = r_reg.busy;
    assign done_out = r_reg.done;

    // ----------------------------------------
    // bus ports
    // ----------------------------------------
    apb_slave_port u_slave (
        .mclk_in     (mclk_in),
        .rst_in      (rst_in),
        .psel_in     (psel_in),
        .penable_in  (penable_in),
        .pwrite_in   (pwrite_in),
        .rdata_in    (reg_rdata),
        .err_in      (reg_err),
        .pready_out  (pready_out),
        .prdata_out  (prdata_out),
        .pslverr_out (pslverr_out),
        .wr_out      (wr_en)
    );

    apb_req_master #(.AW(DEV_AW)) u_master (
        .mclk_in     (mclk_in),
        .rst_in      (rst_in),
        .req_in      (r_reg.req),
        .wr_in       (op.kind == OP_WR),
        .addr_in     (op.addr),
        .wdata_in    (op.data),
        .prdata_in   (dev_prdata_in),
        .pready_in   (dev_pready_in),
        .psel_out    (dev_psel_out),
        .penable_out (dev_penable_out),
        .pwrite_out  (dev_pwrite_out),
        .paddr_out   (dev_paddr_out),
        .pwdata_out  (dev_pwdata_out),
        .ack_out     (ack),
        .rdata_out   (rdata)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    sequence poll_miss;
        r_reg.st == S_WAIT && ack && op.kind == OP_POLL && (rdata & op.data) == 32'h0000_0000;
    endsequence
    sequence last_ack;
        r_reg.st == S_WAIT && ack && r_reg.step == STEP_LAST;
    endsequence
    sequence pll_off_fetch;
        r_reg.st == S_FETCH && r_reg.step == 5'd13 && !r_reg.cfg[CFG_PLL];
    endsequence

    a_step_order: assert property (r_reg.busy && $past(r_reg.busy) |-> r_reg.step >= $past(r_reg.step))
        else $error("step went backwards");
    a_sub_init: assert property (r_reg.st == S_FETCH && r_reg.step == 5'd0
        |=> r_reg.req && op.addr == D_SUB_CTRL && op.data == OSC_STOP)
        else $error("sub init write missing");
    a_main_skip: assert property (r_reg.st == S_FETCH && r_reg.step inside {[5:8]} && !r_reg.cfg[CFG_MAIN]
        |=> !r_reg.req && r_reg.st == S_FETCH)
        else $error("unused main oscillator touched");
    a_fast_power: assert property (r_reg.req && op.addr == D_FAST_CTRL
        |-> op.data == (r_reg.cfg[CFG_FAST] ? OSC_RUN : OSC_STOP))
        else $error("fast oscillator power wrong");
    a_fast_freq: assert property (r_reg.req && op.addr == D_FAST_FREQ
        |-> r_reg.cfg[CFG_FAST] && op.data[1:0] == r_reg.cfg[CFG_FREQ +: 2] && r_reg.step == 5'd10)
        else $error("fast frequency write wrong");
    a_pll_off: assert property (pll_off_fetch |=> r_reg.req && op.addr == D_PLL_CTRL && op.data == OSC_STOP)
        else $error("pll not powered off");
    a_pll_cfg: assert property (r_reg.req && op.addr == D_PLL_CFG
        |-> r_reg.cfg[CFG_PLL] && op.data[15:0] == r_reg.pll[15:0] && r_reg.step == 5'd14)
        else $error("pll ratio write wrong");
    a_poll_hold: assert property (poll_miss |=> r_reg.req && r_reg.st == S_WAIT && r_reg.step == $past(r_reg.step))
        else $error("advanced without stable flag");
    a_done_flag: assert property (last_ack |-> ##2 r_reg.st == S_DONE ##1 r_reg.done && !r_reg.busy)
        else $error("done not raised after switch");
    a_switch_last: assert property (r_reg.req && op.addr == D_SYS_SEL
        |-> r_reg.step == STEP_LAST && op.data[1:0] == r_reg.cfg[CFG_SRC +: 2])
        else $error("source switch out of place");
endmodule // clock_bringup_sequencer

// File: dev_model.sv
// Purpose: device model behind the controller's APB master
// Assumes: ctrl 0 starts a source, 1 stops it
// Notes:   a flags read returns the state latched at the previous flags read, so a poll retries at most once
`timescale 1ns/10ps
module dev_model (
    input  wire logic        mclk_in,    // clock
    input  wire logic        rst_in,     // sync reset
    input  wire logic        psel_in,    // select
    input  wire logic        penable_in, // enable
    input  wire logic        pwrite_in,  // direction
    input  wire logic [7:0]  paddr_in,   // address
    input  wire logic [31:0] pwdata_in,  // write data
    output logic [31:0]      prdata_out, // read data
    output logic             pready_out  // ready
);
    import clk_seq_pkg::*;
    logic [31:0] mem [0:15];
    logic [3:0]  flg;
    logic [3:0]  pend;
    logic [7:0]  wlog [$];
    logic        slow;
    wire         acc = psel_in && penable_in;
    // released bus shows junk, not the last value
    assign prdata_out = !pready_out ? ~mem[0] : paddr_in == D_FLAGS ? {28'h0, flg} : mem[paddr_in[5:2]];
    always_ff @(posedge mclk_in) begin
        // first answer comes one cycle late, later ones promptly
        pready_out <= !rst_in && acc && !pready_out && slow;
        slow       <= !rst_in && (acc ? !slow : slow);
        if (rst_in) begin
            flg  <= '0;
            pend <= '0;
        end else if (acc && pready_out && pwrite_in) begin
            mem[paddr_in[5:2]] <= pwdata_in;
            wlog.push_back(paddr_in);
            case (paddr_in)
                D_SUB_CTRL:  pend[FLAG_SUB]  <= !pwdata_in[0];
                D_MAIN_CTRL: pend[FLAG_MAIN] <= !pwdata_in[0];
                D_FAST_CTRL: pend[FLAG_FAST] <= !pwdata_in[0];
                D_PLL_CTRL:  pend[FLAG_PLL]  <= !pwdata_in[0];
                default: ;
            endcase
        end else if (acc && pready_out && paddr_in == D_FLAGS) begin
            flg <= pend;
        end
    end
endmodule // dev_model

// File: clock_bringup_sequencer_tb.sv
// Purpose: self-checking bench for the clock bring-up controller
// Assumes: device model answers in two or three access cycles
// Notes:   default run from reset, a rerun with every source used, then a run on the fast oscillator
`timescale 1ns/10ps
`define CMP(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module clock_bringup_sequencer_tb;
    import clk_seq_pkg::*;
    logic        mclk_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0, e;
    logic [7:0]  paddr = '0, dpa;
    logic [31:0] pwdata = '0, pr, dpw, dpr, q;
    logic        pready, pslverr, dps, dpe, dpwr, drdy, busy, done;
    int          fails = 0, samples_checked = 0, cyc = 0;
    always #2.5 mclk_in = ~mclk_in;
    clock_bringup_sequencer i_dut (.mclk_in, .rst_in, .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .prdata_out(pr), .pslverr_out(pslverr),
        .dev_psel_out(dps), .dev_penable_out(dpe), .dev_pwrite_out(dpwr), .dev_paddr_out(dpa),
        .dev_pwdata_out(dpw), .dev_prdata_in(dpr), .dev_pready_in(drdy), .busy_out(busy), .done_out(done));
    dev_model i_dev (.mclk_in, .rst_in, .psel_in(dps), .penable_in(dpe), .pwrite_in(dpwr),
        .paddr_in(dpa), .pwdata_in(dpw), .prdata_out(dpr), .pready_out(drdy));
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk_in);
        penable <= 1'b1;
        do @(posedge mclk_in); while (pready !== 1'b1);
        q = pr;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        xfer(1'b0, a, 32'h0);
        `CMP(q, x)
    endtask
    task automatic chklog(input logic [7:0] x[$]);
        `CMP(i_dev.wlog.size(), x.size())
        foreach (x[i]) `CMP(i_dev.wlog[i], x[i])
        i_dev.wlog.delete();
    endtask
    task automatic end_of_test();
        $display("checks=%0d fails=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            end_of_test();
        end
    end
    initial begin
        repeat (6) @(posedge mclk_in);
        rst_in <= 1'b0;
        // config write during the automatic run must be ignored
        xfer(1'b1, R_CFG, 32'h0000_00CF);
        rd(R_CFG, CFG_DEF);
        rd(R_MAIN, MAIN_DEF);
        rd(R_SUB, SUB_DEF);
        rd(R_PLL, PLL_DEF);
        rd(R_DIV, DIV_DEF);
        do @(posedge mclk_in); while (done !== 1'b1);
        chklog('{8'h00, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h24, 8'h20, 8'h2C, 8'h30, 8'h34});
        `CMP(i_dev.mem[0], OSC_STOP)
        `CMP(i_dev.mem[4], 32'h53)
        `CMP(i_dev.mem[6], OSC_STOP)
        `CMP(i_dev.mem[9], PLL_DEF)
        `CMP(i_dev.mem[11], {30'h0, PWR_HIGH})
        `CMP(i_dev.mem[12], DIV_DEF)
        `CMP(i_dev.mem[13], {30'h0, SRC_PLL})
        xfer(1'b1, 8'h40, 32'h0);
        `CMP(e, 1'b1)
        xfer(1'b1, R_CFG, 32'h0000_00CF);
        xfer(1'b1, R_SUB, 32'h0000_2144);
        xfer(1'b1, R_CTRL, 32'h1);
        do @(posedge mclk_in); while (busy !== 1'b1);
        do @(posedge mclk_in); while (done !== 1'b1);
        chklog('{8'h00, 8'h04, 8'h08, 8'h00, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h18, 8'h24, 8'h20, 8'h2C, 8'h30, 8'h34});
        `CMP(i_dev.mem[1], 32'h44)
        `CMP(i_dev.mem[7], {30'h0, FREQ_16})
        `CMP(i_dev.mem[6], OSC_RUN)
        `CMP(i_dev.mem[13], {30'h0, SRC_SUB})
        rd(R_STATUS, 32'h0000_1402);
        `CMP(busy, 1'b0)
        // main and pll unused, fast oscillator at 18 MHz drives the system clock
        xfer(1'b1, R_CFG, 32'h0000_0054);
        xfer(1'b1, R_CTRL, 32'h1);
        do @(posedge mclk_in); while (busy !== 1'b1);
        do @(posedge mclk_in); while (done !== 1'b1);
        chklog('{8'h00, 8'h1C, 8'h18, 8'h20, 8'h2C, 8'h30, 8'h34});
        `CMP(i_dev.mem[8], OSC_STOP)
        `CMP(i_dev.mem[7], {30'h0, FREQ_18})
        `CMP(i_dev.mem[13], {30'h0, SRC_FAST})
        end_of_test();
    end
endmodule // clock_bringup_sequencer_tb
